/* verilog/aiacl_regs.svh */
// register offsets, field positions, reset values and frame constants
`ifndef AIACL_REGS_SVH
`define AIACL_REGS_SVH
// What this block does
// - Sender check: 1 needs an ARP frame whose SHA equals the source MAC, 0 needs them to differ, any skips it.
// - Target check: 1 needs a RARP frame whose THA equals the source MAC, 0 needs them to differ, any skips it.
// - Length check: qualifying is HLN 0x06 and PLN 0x04; 1 needs it, 0 needs its absence, any skips it.
// - Hardware-space check: 1 needs HRD equal to 1, 0 forbids it, any skips it.
// - Protocol-space check: 1 needs PRO equal to 0x800, 0 forbids it, any skips it.
// - ICMP type test is either ignored or needs the type to equal a set value 0 to 255.
// - ICMP code test is either ignored or needs the code to equal a set value 0 to 255.
// - Source port test has three modes: any, specific and range.
// - Specific mode needs the 16-bit source port to equal the set value.
// - Range mode needs the source port to lie between the two set bounds.
`define AIACL_ARP_CTRL_OFS 8'h00
`define AIACL_ICMP_CTRL_OFS 8'h04
`define AIACL_PORT_CTRL_OFS 8'h08
`define AIACL_PORT_BOUND_OFS 8'h0C
`define AIACL_STATUS_OFS 8'h10
`define AIACL_FRAME_CNT_OFS 8'h14
`define AIACL_HIT_CNT_OFS 8'h18
`define AIACL_SND_LSB 0
`define AIACL_RTG_LSB 2
`define AIACL_LEN_LSB 4
`define AIACL_HRD_LSB 6
`define AIACL_PRO_LSB 8
`define AIACL_TYPE_EN_BIT 0
`define AIACL_CODE_EN_BIT 1
`define AIACL_TYPE_LSB 8
`define AIACL_CODE_LSB 16
`define AIACL_LO_LSB 0
`define AIACL_HI_LSB 16
`define AIACL_ARP_CTRL_RST 32'h0000_02AA
`define AIACL_ICMP_CTRL_RST 32'h0000_0000
`define AIACL_PORT_CTRL_RST 32'h0000_0000
`define AIACL_PORT_BOUND_RST 32'hFFFF_0000
`define AIACL_ET_ARP 16'h0806
`define AIACL_ET_RARP 16'h8035
`define AIACL_ET_IPV4 16'h0800
`define AIACL_HRD_ETH 16'h0001
`define AIACL_PRO_IP 16'h0800
`define AIACL_HLN_ETH 8'h06
`define AIACL_PLN_IP 8'h04
`define AIACL_IP_VER4 4'h4
`define AIACL_PROTO_ICMP 8'h01
`define AIACL_PROTO_TCP 8'h06
`define AIACL_PROTO_UDP 8'h11
`define AIACL_SRC_FIRST 11'h006
`define AIACL_SRC_LAST 11'h00B
`define AIACL_ET_FIRST 11'h00C
`define AIACL_ET_LAST 11'h00D
`define AIACL_L3_FIRST 11'h00E
`define AIACL_HRD_LAST 11'h00F
`define AIACL_PRO_FIRST 11'h010
`define AIACL_PRO_LAST 11'h011
`define AIACL_HLN_OFS 11'h012
`define AIACL_PLN_OFS 11'h013
`define AIACL_SHA_FIRST 11'h016
`define AIACL_SHA_LAST 11'h01B
`define AIACL_IPPROTO_OFS 11'h017
`define AIACL_THA_FIRST 11'h020
`define AIACL_THA_LAST 11'h025
`define AIACL_CNT_MAX 11'h7FF
`endif

/* verilog/aiacl_pkg.sv */
// types shared by the entry matcher
package aiacl_pkg;
  typedef enum logic [1:0] {
    AIACL_TS_NE = 2'b00,
    AIACL_TS_EQ = 2'b01,
    AIACL_TS_ANY = 2'b10
  } aiacl_tri_t;
  typedef enum logic [1:0] {
    AIACL_PM_ANY = 2'b00,
    AIACL_PM_SPEC = 2'b01,
    AIACL_PM_RANGE = 2'b10
  } aiacl_pmode_t;
  typedef enum logic [0:0] {
    AIACL_PS_IDLE = 1'b0,
    AIACL_PS_BODY = 1'b1
  } aiacl_pstate_t;
endpackage : aiacl_pkg

/* verilog/aiacl_frame_parser.sv */
// header field capture from the received byte stream
`timescale 1ns/10ps
`include "aiacl_regs.svh"
module aiacl_frame_parser (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // received bytes
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  // captured fields
  output logic [47:0] frame_source_mac,
  output logic [47:0] sha,
  output logic [47:0] tha,
  output logic [15:0] ethertype,
  output logic [15:0] hrd,
  output logic [15:0] pro,
  output logic [7:0] hln,
  output logic [7:0] pln,
  output logic [7:0] ver_ihl,
  output logic [7:0] ip_proto,
  output logic [15:0] l4_word,
  output logic arp_ok,
  output logic l4_ok,
  output logic done
);
  aiacl_pkg::aiacl_pstate_t st_q, st_d;
  logic [10:0] cnt_q, cnt_d, idx, l4s;
  logic [47:0] src_q, src_d, sha_q, sha_d, tha_q, tha_d;
  logic [15:0] et_q, et_d, hrd_q, hrd_d, pro_q, pro_d, l4_q, l4_d;
  logic [7:0] hln_q, hln_d, pln_q, pln_d, vihl_q, vihl_d, prot_q, prot_d;
  logic aok_q, aok_d, lok_q, lok_d, done_q, done_d, take;

  // bytes outside a frame are dropped
  assign take = rx_valid && (rx_sof || st_q == aiacl_pkg::AIACL_PS_BODY);
  assign idx = rx_sof ? 11'h000 : cnt_q;
  // transport header starts after the variable ip header
  assign l4s = `AIACL_L3_FIRST + {5'h00, vihl_q[3:0], 2'b00};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    src_d = src_q;
    sha_d = sha_q;
    tha_d = tha_q;
    et_d = et_q;
    hrd_d = hrd_q;
    pro_d = pro_q;
    l4_d = l4_q;
    hln_d = hln_q;
    pln_d = pln_q;
    vihl_d = vihl_q;
    prot_d = prot_q;
    aok_d = aok_q && !(rx_valid && rx_sof);
    lok_d = lok_q && !(rx_valid && rx_sof);
    done_d = 1'b0;
    if (take) begin
      cnt_d = (idx == `AIACL_CNT_MAX) ? idx : idx + 11'h001;
      st_d = rx_eof ? aiacl_pkg::AIACL_PS_IDLE : aiacl_pkg::AIACL_PS_BODY;
      done_d = rx_eof;
      // standard field positions, untagged frames
      if (idx >= `AIACL_SRC_FIRST && idx <= `AIACL_SRC_LAST) src_d = {src_q[39:0], rx_data};
      if (idx >= `AIACL_ET_FIRST && idx <= `AIACL_ET_LAST) et_d = {et_q[7:0], rx_data};
      if (idx >= `AIACL_L3_FIRST && idx <= `AIACL_HRD_LAST) hrd_d = {hrd_q[7:0], rx_data};
      if (idx >= `AIACL_PRO_FIRST && idx <= `AIACL_PRO_LAST) pro_d = {pro_q[7:0], rx_data};
      if (idx >= `AIACL_SHA_FIRST && idx <= `AIACL_SHA_LAST) sha_d = {sha_q[39:0], rx_data};
      if (idx >= `AIACL_THA_FIRST && idx <= `AIACL_THA_LAST) tha_d = {tha_q[39:0], rx_data};
      if (idx == `AIACL_L3_FIRST) vihl_d = rx_data;
      if (idx == `AIACL_HLN_OFS) hln_d = rx_data;
      if (idx == `AIACL_PLN_OFS) pln_d = rx_data;
      if (idx == `AIACL_IPPROTO_OFS) prot_d = rx_data;
      if (idx == `AIACL_THA_LAST) aok_d = 1'b1;
      if (idx > `AIACL_L3_FIRST && idx == l4s) l4_d = {rx_data, l4_q[7:0]};
      if (idx > `AIACL_L3_FIRST && idx == l4s + 11'h001) begin
        l4_d = {l4_q[15:8], rx_data};
        lok_d = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= aiacl_pkg::AIACL_PS_IDLE;
      cnt_q <= 11'h000;
      src_q <= 48'h0;
      sha_q <= 48'h0;
      tha_q <= 48'h0;
      et_q <= 16'h0;
      hrd_q <= 16'h0;
      pro_q <= 16'h0;
      l4_q <= 16'h0;
      hln_q <= 8'h00;
      pln_q <= 8'h00;
      vihl_q <= 8'h00;
      prot_q <= 8'h00;
      aok_q <= 1'b0;
      lok_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      src_q <= src_d;
      sha_q <= sha_d;
      tha_q <= tha_d;
      et_q <= et_d;
      hrd_q <= hrd_d;
      pro_q <= pro_d;
      l4_q <= l4_d;
      hln_q <= hln_d;
      pln_q <= pln_d;
      vihl_q <= vihl_d;
      prot_q <= prot_d;
      aok_q <= aok_d;
      lok_q <= lok_d;
      done_q <= done_d;
    end
  end

  assign frame_source_mac = src_q;
  assign sha = sha_q;
  assign tha = tha_q;
  assign ethertype = et_q;
  assign hrd = hrd_q;
  assign pro = pro_q;
  assign hln = hln_q;
  assign pln = pln_q;
  assign ver_ihl = vihl_q;
  assign ip_proto = prot_q;
  assign l4_word = l4_q;
  assign arp_ok = aok_q;
  assign l4_ok = lok_q;
  assign done = done_q;
endmodule : aiacl_frame_parser

/* verilog/aiacl_ace_eval.sv */
// per-test evaluation of one access control entry
`timescale 1ns/10ps
`include "aiacl_regs.svh"
module aiacl_ace_eval (
  // captured fields
  input wire logic [47:0] frame_source_mac,
  input wire logic [47:0] sha,
  input wire logic [47:0] tha,
  input wire logic [15:0] ethertype,
  input wire logic [15:0] hrd,
  input wire logic [15:0] pro,
  input wire logic [7:0] hln,
  input wire logic [7:0] pln,
  input wire logic [7:0] ver_ihl,
  input wire logic [7:0] ip_proto,
  input wire logic [15:0] l4_word,
  input wire logic arp_ok,
  input wire logic l4_ok,
  // entry settings
  input wire aiacl_pkg::aiacl_tri_t arp_sender_addr_check,
  input wire aiacl_pkg::aiacl_tri_t rarp_target_addr_check,
  input wire aiacl_pkg::aiacl_tri_t addr_length_check,
  input wire aiacl_pkg::aiacl_tri_t hrd_space_check,
  input wire aiacl_pkg::aiacl_tri_t pro_space_check,
  input wire logic icmp_type_test_mode,
  input wire logic icmp_code_test_mode,
  input wire logic [7:0] icmp_type_value,
  input wire logic [7:0] icmp_code_value,
  input wire aiacl_pkg::aiacl_pmode_t l4_src_port_test_mode,
  input wire logic [15:0] port_lo,
  input wire logic [15:0] port_hi,
  // results
  output logic [7:0] test_pass,
  output logic hit
);
  logic is_arp, is_rarp, is_ip, is_icmp, is_l4, arp_kind;

  // encoding 2'b11 behaves as don't-care
  function automatic logic tri_ok(input aiacl_pkg::aiacl_tri_t m, input logic kind,
                                  input logic c);
    case (m)
      aiacl_pkg::AIACL_TS_NE: tri_ok = kind && !c;
      aiacl_pkg::AIACL_TS_EQ: tri_ok = kind && c;
      default: tri_ok = 1'b1;
    endcase
  endfunction : tri_ok

  assign is_arp = (ethertype == `AIACL_ET_ARP) && arp_ok;
  assign is_rarp = (ethertype == `AIACL_ET_RARP) && arp_ok;
  assign arp_kind = is_arp || is_rarp;
  assign is_ip = (ethertype == `AIACL_ET_IPV4) && (ver_ihl[7:4] == `AIACL_IP_VER4) && l4_ok;
  assign is_icmp = is_ip && (ip_proto == `AIACL_PROTO_ICMP);
  assign is_l4 = is_ip && (ip_proto == `AIACL_PROTO_TCP || ip_proto == `AIACL_PROTO_UDP);

  always_comb begin
    test_pass[0] = tri_ok(arp_sender_addr_check, is_arp, sha == frame_source_mac);
    test_pass[1] = tri_ok(rarp_target_addr_check, is_rarp, tha == frame_source_mac);
    test_pass[2] = tri_ok(addr_length_check, arp_kind,
                          hln == `AIACL_HLN_ETH && pln == `AIACL_PLN_IP);
    test_pass[3] = tri_ok(hrd_space_check, arp_kind, hrd == `AIACL_HRD_ETH);
    test_pass[4] = tri_ok(pro_space_check, arp_kind, pro == `AIACL_PRO_IP);
    test_pass[5] = !icmp_type_test_mode || (is_icmp && l4_word[15:8] == icmp_type_value);
    test_pass[6] = !icmp_code_test_mode || (is_icmp && l4_word[7:0] == icmp_code_value);
    case (l4_src_port_test_mode)
      aiacl_pkg::AIACL_PM_SPEC: test_pass[7] = is_l4 && l4_word == port_lo;
      aiacl_pkg::AIACL_PM_RANGE: test_pass[7] = is_l4 && l4_word >= port_lo
                                                && l4_word <= port_hi;
      default: test_pass[7] = 1'b1;
    endcase
  end

  assign hit = &test_pass;
endmodule : aiacl_ace_eval

/* verilog/aiacl_matcher.sv */
// entry matcher top: AHB-Lite register slave, frame parser and entry evaluator
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "aiacl_regs.svh"
module aiacl_matcher (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // received frame bytes
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  // match result
  output logic match_valid,
  output logic match_hit
);
  logic [31:0] arp_ctrl_q, arp_ctrl_d, icmp_ctrl_q, icmp_ctrl_d;
  logic [31:0] port_ctrl_q, port_ctrl_d, port_bound_q, port_bound_d;
  logic [31:0] hrdata_q, hrdata_d, rd_mux;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic wr_pend_q, wr_pend_d, acc;
  logic [31:0] frame_cnt_q, frame_cnt_d, hit_cnt_q, hit_cnt_d;
  logic [7:0] pass_q, pass_d;
  logic valid_q, valid_d, hit_q, hit_d, seen_q, seen_d, cnt_clr;
  logic [47:0] f_src, f_sha, f_tha;
  logic [15:0] f_et, f_hrd, f_pro, f_l4;
  logic [7:0] f_hln, f_pln, f_vihl, f_proto, test_pass;
  logic f_aok, f_lok, f_done, ace_hit;
  aiacl_pkg::aiacl_tri_t m_snd, m_rtg, m_len, m_hrd, m_pro;
  aiacl_pkg::aiacl_pmode_t m_port;
  logic [15:0] p_lo, p_hi;
  logic t_en, c_en;
  logic [7:0] t_val, c_val;

  // register fields steering the evaluator
  assign m_snd = aiacl_pkg::aiacl_tri_t'(arp_ctrl_q[`AIACL_SND_LSB +: 2]);
  assign m_rtg = aiacl_pkg::aiacl_tri_t'(arp_ctrl_q[`AIACL_RTG_LSB +: 2]);
  assign m_len = aiacl_pkg::aiacl_tri_t'(arp_ctrl_q[`AIACL_LEN_LSB +: 2]);
  assign m_hrd = aiacl_pkg::aiacl_tri_t'(arp_ctrl_q[`AIACL_HRD_LSB +: 2]);
  assign m_pro = aiacl_pkg::aiacl_tri_t'(arp_ctrl_q[`AIACL_PRO_LSB +: 2]);
  assign t_en = icmp_ctrl_q[`AIACL_TYPE_EN_BIT];
  assign c_en = icmp_ctrl_q[`AIACL_CODE_EN_BIT];
  assign t_val = icmp_ctrl_q[`AIACL_TYPE_LSB +: 8];
  assign c_val = icmp_ctrl_q[`AIACL_CODE_LSB +: 8];
  assign m_port = aiacl_pkg::aiacl_pmode_t'(port_ctrl_q[1:0]);
  assign p_lo = port_bound_q[`AIACL_LO_LSB +: 16];
  assign p_hi = port_bound_q[`AIACL_HI_LSB +: 16];

  aiacl_frame_parser u_parser (
    .hclk(hclk),
    .hresetn(hresetn),
    .rx_valid(rx_valid),
    .rx_sof(rx_sof),
    .rx_eof(rx_eof),
    .rx_data(rx_data),
    .frame_source_mac(f_src),
    .sha(f_sha),
    .tha(f_tha),
    .ethertype(f_et),
    .hrd(f_hrd),
    .pro(f_pro),
    .hln(f_hln),
    .pln(f_pln),
    .ver_ihl(f_vihl),
    .ip_proto(f_proto),
    .l4_word(f_l4),
    .arp_ok(f_aok),
    .l4_ok(f_lok),
    .done(f_done)
  );

  aiacl_ace_eval u_eval (
    .frame_source_mac(f_src),
    .sha(f_sha),
    .tha(f_tha),
    .ethertype(f_et),
    .hrd(f_hrd),
    .pro(f_pro),
    .hln(f_hln),
    .pln(f_pln),
    .ver_ihl(f_vihl),
    .ip_proto(f_proto),
    .l4_word(f_l4),
    .arp_ok(f_aok),
    .l4_ok(f_lok),
    .arp_sender_addr_check(m_snd),
    .rarp_target_addr_check(m_rtg),
    .addr_length_check(m_len),
    .hrd_space_check(m_hrd),
    .pro_space_check(m_pro),
    .icmp_type_test_mode(t_en),
    .icmp_code_test_mode(c_en),
    .icmp_type_value(t_val),
    .icmp_code_value(c_val),
    .l4_src_port_test_mode(m_port),
    .port_lo(p_lo),
    .port_hi(p_hi),
    .test_pass(test_pass),
    .hit(ace_hit)
  );

  // zero-wait slave, every transfer answered OKAY
  assign acc = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign match_valid = valid_q;
  assign match_hit = hit_q;

  always_comb begin
    case (haddr)
      `AIACL_ARP_CTRL_OFS: rd_mux = arp_ctrl_q;
      `AIACL_ICMP_CTRL_OFS: rd_mux = icmp_ctrl_q;
      `AIACL_PORT_CTRL_OFS: rd_mux = port_ctrl_q;
      `AIACL_PORT_BOUND_OFS: rd_mux = port_bound_q;
      `AIACL_STATUS_OFS: rd_mux = {16'h0000, pass_q, 6'h00, seen_q, hit_q};
      `AIACL_FRAME_CNT_OFS: rd_mux = frame_cnt_q;
      `AIACL_HIT_CNT_OFS: rd_mux = hit_cnt_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus and configuration state
  always_comb begin
    wr_pend_d = acc && hwrite;
    wr_addr_d = acc ? haddr : wr_addr_q;
    hrdata_d = (acc && !hwrite) ? rd_mux : hrdata_q;
    arp_ctrl_d = arp_ctrl_q;
    icmp_ctrl_d = icmp_ctrl_q;
    port_ctrl_d = port_ctrl_q;
    port_bound_d = port_bound_q;
    cnt_clr = 1'b0;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `AIACL_ARP_CTRL_OFS: arp_ctrl_d = {22'h000000, hwdata[9:0]};
        `AIACL_ICMP_CTRL_OFS: icmp_ctrl_d = {8'h00, hwdata[23:8], 6'h00, hwdata[1:0]};
        `AIACL_PORT_CTRL_OFS: port_ctrl_d = {30'h00000000, hwdata[1:0]};
        `AIACL_PORT_BOUND_OFS: port_bound_d = hwdata;
        `AIACL_FRAME_CNT_OFS: cnt_clr = 1'b1;
        default: cnt_clr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      arp_ctrl_q <= `AIACL_ARP_CTRL_RST;
      icmp_ctrl_q <= `AIACL_ICMP_CTRL_RST;
      port_ctrl_q <= `AIACL_PORT_CTRL_RST;
      port_bound_q <= `AIACL_PORT_BOUND_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      arp_ctrl_q <= arp_ctrl_d;
      icmp_ctrl_q <= icmp_ctrl_d;
      port_ctrl_q <= port_ctrl_d;
      port_bound_q <= port_bound_d;
    end
  end

  // result and counters; a frame ending during a clear still counts
  always_comb begin
    valid_d = f_done;
    hit_d = f_done ? ace_hit : hit_q;
    pass_d = f_done ? test_pass : pass_q;
    seen_d = seen_q || f_done;
    frame_cnt_d = cnt_clr ? 32'h0000_0000 : frame_cnt_q;
    hit_cnt_d = cnt_clr ? 32'h0000_0000 : hit_cnt_q;
    if (f_done) begin
      frame_cnt_d = frame_cnt_d + 32'h0000_0001;
      if (ace_hit) hit_cnt_d = hit_cnt_d + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_q <= 1'b0;
      hit_q <= 1'b0;
      pass_q <= 8'h00;
      seen_q <= 1'b0;
      frame_cnt_q <= 32'h0000_0000;
      hit_cnt_q <= 32'h0000_0000;
    end else begin
      valid_q <= valid_d;
      hit_q <= hit_d;
      pass_q <= pass_d;
      seen_q <= seen_d;
      frame_cnt_q <= frame_cnt_d;
      hit_cnt_q <= hit_cnt_d;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_done;
    f_done;
  endsequence
  sequence s_miss;
    valid_q && !hit_q;
  endsequence

  sender_mismatch_a: assert property (s_done and (m_snd == aiacl_pkg::AIACL_TS_EQ
    && f_sha != f_src) |=> s_miss) else $error("sender check passed a mismatch");
  target_equal_a: assert property (s_done and (m_rtg == aiacl_pkg::AIACL_TS_NE
    && f_tha == f_src) |=> s_miss) else $error("target check passed an equal THA");
  length_bad_a: assert property (s_done and (m_len == aiacl_pkg::AIACL_TS_EQ
    && f_hln != `AIACL_HLN_ETH) |=> s_miss) else $error("length check passed bad HLN");
  hrd_forbid_a: assert property (s_done and (m_hrd == aiacl_pkg::AIACL_TS_NE
    && f_hrd == `AIACL_HRD_ETH) |=> s_miss) else $error("hrd check passed HRD 1");
  pro_require_a: assert property (s_done and (m_pro == aiacl_pkg::AIACL_TS_EQ
    && f_pro != `AIACL_PRO_IP) |=> s_miss) else $error("pro check passed wrong PRO");
  icmp_type_a: assert property (s_done and (t_en && f_l4[15:8] != t_val)
    |=> s_miss) else $error("icmp type mismatch matched");
  icmp_code_a: assert property (s_done and (c_en && f_l4[7:0] != c_val)
    |=> s_miss) else $error("icmp code mismatch matched");
  port_spec_a: assert property (s_done and (m_port == aiacl_pkg::AIACL_PM_SPEC
    && f_l4 != p_lo) |=> s_miss) else $error("specific port mismatch matched");
  port_range_a: assert property (s_done and (m_port == aiacl_pkg::AIACL_PM_RANGE
    && (f_l4 < p_lo || f_l4 > p_hi)) |=> s_miss) else $error("port outside range matched");
  port_any_a: assert property (s_done and (m_port == aiacl_pkg::AIACL_PM_ANY)
    |=> pass_q[7]) else $error("port any did not pass");
  all_any_hit_a: assert property (s_done and (arp_ctrl_q == `AIACL_ARP_CTRL_RST && !t_en
    && !c_en && m_port == aiacl_pkg::AIACL_PM_ANY) |=> valid_q && hit_q)
    else $error("all don't-care entry missed");
  arp_kind_a: assert property (s_done and ((m_len == aiacl_pkg::AIACL_TS_NE
    || m_len == aiacl_pkg::AIACL_TS_EQ) && f_et != `AIACL_ET_ARP && f_et != `AIACL_ET_RARP)
    |=> s_miss)
    else $error("arp test matched a non-arp frame");
  result_pulse_a: assert property (s_done |=> valid_q ##1 (!valid_q || $past(f_done)))
    else $error("match_valid not a single pulse");
endmodule : aiacl_matcher

/* tb/aiacl_rx_src.sv */
// frame byte source standing in for a switch port
`timescale 1ns/10ps
module aiacl_rx_src (
  // clock
  input wire logic hclk,
  // frame bytes towards the matcher
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic [7:0] rx_data
);
  logic [7:0] q[$];
  bit slow = 0;
  bit at_sof = 1;
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h00;
  end
  // slow mode leaves random gaps between bytes
  always @(posedge hclk) begin
    if (q.size() != 0 && !(slow && $urandom_range(1))) begin
      rx_valid <= 1'b1;
      rx_sof <= at_sof;
      rx_eof <= (q.size() == 1);
      rx_data <= q.pop_front();
      at_sof = (q.size() == 0);
    end else begin
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_eof <= 1'b0;
      // idle data keeps toggling so a stale byte is never reused
      rx_data <= ~rx_data;
    end
  end
endmodule : aiacl_rx_src

/* tb/tb_top.sv */
// self-checking bench for the entry matcher
`timescale 1ns/10ps
`include "aiacl_regs.svh"
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, match_valid, match_hit;
  logic rx_valid, rx_sof, rx_eof;
  logic [7:0] haddr, rx_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic exp_q[$];
  int errors = 0;
  int check_count = 0;
  int seen = 0;
  int nfr = 0;
  int nhit = 0;
  assign hready = hreadyout;
  aiacl_matcher u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .match_valid(match_valid),
    .match_hit(match_hit));
  aiacl_rx_src u_src (.hclk(hclk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic finish_test;
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic give_up;
    errors++;
    finish_test();
  endtask : give_up
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    if (n >= 100) give_up();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb
  function automatic logic tri_ok(logic [1:0] s, logic ok, logic c);
    return s[1] ? 1'b1 : (ok && (c == s[0]));
  endfunction : tri_ok
  // result monitor
  always @(negedge hclk) if (match_valid === 1'b1) begin
    seen++;
    if (exp_q.size() == 0) chk("match_spare", 32'h0, 32'h1);
    else chk("match_hit", {31'h0, exp_q.pop_front()}, {31'h0, match_hit});
  end
  initial begin
    #400000;
    give_up();
  end
  initial begin
    logic [7:0] b[60];
    logic [7:0] ofs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
    logic [31:0] rv[5] = '{32'h0000_02AA, 32'h0, 32'h0, 32'hFFFF_0000, 32'h0};
    logic [47:0] sm;
    logic [31:0] ac, ic, pc, r;
    logic [15:0] p, lo, hi;
    logic e;
    int k;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    void'($urandom(32'h32FBD0B7));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ofs[j]) begin
      ahb(ofs[j], 1'b0, 32'h0);
      chk("reset_value", rv[j], rd);
    end
    for (int i = 0; i < 200; i++) begin
      u_src.slow = i[0];
      k = $urandom_range(3);
      r = $urandom;
      sm = {16'($urandom), 32'($urandom)};
      ac = 32'h2AA;
      if (r[8]) for (int j = 0; j < 5; j++) ac[2*j+:2] = 2'($urandom_range(3));
      p = 16'($urandom_range(65534, 1));
      lo = p + 16'($urandom_range(2)) - 16'h1;
      hi = lo + 16'($urandom_range(1));
      ic = {8'h0, p[7:0] ^ 8'(r[9]), p[15:8] ^ 8'(r[10]), 6'h0, r[12:11]};
      pc = {30'h0, r[14:13]};
      foreach (b[j]) b[j] = 8'($urandom);
      {b[6], b[7], b[8], b[9], b[10], b[11]} = sm;
      {b[12], b[13]} = (k == 0) ? 16'h0806 : (k == 1) ? 16'h8035 : 16'h0800;
      {b[14], b[15]} = r[0] ? 16'h0001 : 16'h0006;
      {b[16], b[17]} = r[1] ? 16'h0800 : 16'h86DD;
      b[18] = r[2] ? 8'h06 : 8'h05;
      b[19] = r[3] ? 8'h04 : 8'h03;
      {b[22], b[23], b[24], b[25], b[26], b[27]} = sm ^ {47'h0, r[4]};
      {b[32], b[33], b[34], b[35], b[36], b[37]} = sm ^ {47'h0, r[5]};
      if (k >= 2) begin
        b[14] = 8'h45;
        b[23] = (k == 2) ? 8'h01 : r[15] ? 8'h06 : 8'h11;
        {b[34], b[35]} = p;
      end
      e = tri_ok(ac[1:0], k == 0, !r[4]) & tri_ok(ac[3:2], k == 1, !r[5])
        & tri_ok(ac[5:4], k < 2, r[2] & r[3]) & tri_ok(ac[7:6], k < 2, r[0])
        & tri_ok(ac[9:8], k < 2, r[1])
        & (!ic[0] | (k == 2 && ic[15:8] == p[15:8]))
        & (!ic[1] | (k == 2 && ic[23:16] == p[7:0]))
        & (pc[1:0] == 2'd0 || pc[1:0] == 2'd3
        || (k == 3 && (pc[0] ? p == lo : (p >= lo && p <= hi))));
      ahb(`AIACL_ARP_CTRL_OFS, 1'b1, ac);
      ahb(`AIACL_ICMP_CTRL_OFS, 1'b1, ic);
      ahb(`AIACL_PORT_CTRL_OFS, 1'b1, pc);
      ahb(`AIACL_PORT_BOUND_OFS, 1'b1, {hi, lo});
      exp_q.push_back(e);
      nhit += e;
      nfr++;
      foreach (b[j]) u_src.q.push_back(b[j]);
      k = 0;
      while (seen < nfr && k < 500) begin
        @(posedge hclk);
        k++;
      end
      if (k >= 500) give_up();
      ahb(`AIACL_STATUS_OFS, 1'b0, 32'h0);
      chk("status_hit", {30'h0, 1'b1, e}, {30'h0, rd[1:0]});
    end
    ahb(`AIACL_FRAME_CNT_OFS, 1'b0, 32'h0);
    chk("frame_count", nfr, rd);
    ahb(`AIACL_HIT_CNT_OFS, 1'b0, 32'h0);
    chk("hit_count", nhit, rd);
    ahb(`AIACL_FRAME_CNT_OFS, 1'b1, 32'h0);
    @(posedge hclk);
    ahb(`AIACL_HIT_CNT_OFS, 1'b0, 32'h0);
    chk("hit_count_clear", 32'h0, rd);
    finish_test();
  end
endmodule : tb_top
